// ===== pkg/cpu_port_if.sv
// Asynchronous processor port between the controlling processor and
// the switch. Resolves the shared data bus from the drive enables of both
// ends and the open-drain acknowledge from the switch end alone.
`timescale 1ns/100ps
`default_nettype none

interface cpu_port_if;
    logic chip_select_n;
    logic data_strobe;
    logic read_write;
    logic [5:0] port_addr;
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic [7:0] dev_data_out;
    logic dev_data_oe;
    logic xfer_ack_n_out;
    logic xfer_ack_oe;
    logic [7:0] port_data;
    logic xfer_ack_n;

    // Bus level: the switch end wins over the host end, an idle bus floats high.
    assign port_data = dev_data_oe ? dev_data_out :
                       (host_data_oe ? host_data_out : 8'hFF);
    // Open drain with pull-up: low only while the switch pulls it.
    assign xfer_ack_n = xfer_ack_oe ? xfer_ack_n_out : 1'b1;

    modport device (
        input chip_select_n, data_strobe, read_write, port_addr, port_data,
        output dev_data_out, dev_data_oe, xfer_ack_n_out, xfer_ack_oe
    );

    modport host (
        output chip_select_n, data_strobe, read_write, port_addr,
        output host_data_out, host_data_oe,
        input port_data, xfer_ack_n
    );
endinterface

`default_nettype wire

// ===== pkg/tdm_switch_defines.svh
// Constants of the time-division switch and its processor port.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef TDM_SWITCH_DEFINES_SVH
`define TDM_SWITCH_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SYS_CLK_MHZ 40
`define BIT_CLK_KHZ 4096
`define STREAM_KBPS 2048
`define FRAME_US 125
`define FRAME_TICKS (`FRAME_US * `BIT_CLK_KHZ / 1000)
`define TICKS_PER_BIT (`BIT_CLK_KHZ / `STREAM_KBPS)
`define STREAMS 8
`define CHANNELS 32

// ----------------------------------------------------------------------
// Processor port address and control byte layout
// ----------------------------------------------------------------------
`define ADDR_MEM_BIT 5
`define CTRL_SPLIT_BIT 7
`define CTRL_MSG_BIT 6
`define CTRL_SEL_HI 4
`define CTRL_SEL_LO 3
`define CTRL_STREAM_HI 2
`define CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Upper connection memory bits
// ----------------------------------------------------------------------
`define CMH_OE_BIT 0
`define CMH_CST_BIT 1
`define CMH_MSG_BIT 2

`endif

// ===== pkg/tdm_switch_pkg.sv
// Types shared by the switch end and the processor end.
// Assumes the defines header is on the include path.
package tdm_switch_pkg;

    // ------------------------------------------------------------------
    // Memory selection held in the control byte
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_DATA_ALT = 2'h0,
        SEL_DATA = 2'h1,
        SEL_CONN_LO = 2'h2,
        SEL_CONN_HI = 2'h3
    } mem_sel_t;

    // ------------------------------------------------------------------
    // Access state machines, one bit changes per step except the return to idle
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DEV_IDLE = 2'h0,
        DEV_BUSY = 2'h1,
        DEV_ACK = 2'h3
    } dev_state_t;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'h0,
        HOST_STROBE = 2'h1,
        HOST_RELEASE = 2'h3
    } host_state_t;

endpackage

// ===== rtl/cpu_port_master.sv
// Processor end of the switch port: turns one user request into a
// strobed access and waits for the switch to acknowledge it.
// Assumes the acknowledge line is pulled up when nobody drives it.
`timescale 1ns/100ps
`default_nettype none
`include "tdm_switch_defines.svh"

module cpu_port_master (
    input wire logic clk,
    input wire logic rst,
    cpu_port_if.host bus,
    input wire logic req,
    input wire logic req_write,
    input wire logic [5:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic busy,
    output logic done,
    output logic [7:0] rdata
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tdm_switch_pkg::host_state_t state_ff;
    logic cs_n_ff;
    logic strobe_ff;
    logic rw_ff;
    logic [5:0] addr_ff;
    logic [7:0] wdata_ff;
    logic doe_ff;
    logic busy_ff;
    logic done_ff;
    logic [7:0] rdata_ff;

    // Access sequence: strobe, wait for acknowledge, release, wait.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= tdm_switch_pkg::HOST_IDLE;
            cs_n_ff <= 1'b1;
            strobe_ff <= 1'b0;
            rw_ff <= 1'b1;
            addr_ff <= 6'h00;
            wdata_ff <= 8'h00;
            doe_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                tdm_switch_pkg::HOST_IDLE: begin
                    if (req) begin
                        state_ff <= tdm_switch_pkg::HOST_STROBE;
                        cs_n_ff <= 1'b0;
                        strobe_ff <= 1'b1;
                        rw_ff <= ~req_write;
                        addr_ff <= req_addr;
                        wdata_ff <= req_wdata;
                        doe_ff <= req_write;
                        busy_ff <= 1'b1;
                    end
                end
                tdm_switch_pkg::HOST_STROBE: begin
                    if (!bus.xfer_ack_n) begin
                        state_ff <= tdm_switch_pkg::HOST_RELEASE;
                        rdata_ff <= bus.port_data;
                        cs_n_ff <= 1'b1;
                        strobe_ff <= 1'b0;
                        doe_ff <= 1'b0;
                    end
                end
                tdm_switch_pkg::HOST_RELEASE: begin
                    if (bus.xfer_ack_n) begin
                        state_ff <= tdm_switch_pkg::HOST_IDLE;
                        rw_ff <= 1'b1;
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                    end
                end
                default: begin
                    state_ff <= tdm_switch_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    assign bus.chip_select_n = cs_n_ff;
    assign bus.data_strobe = strobe_ff;
    assign bus.read_write = rw_ff;
    assign bus.port_addr = addr_ff;
    assign bus.host_data_out = wdata_ff;
    assign bus.host_data_oe = doe_ff;
    assign busy = busy_ff;
    assign done = done_ff;
    assign rdata = rdata_ff;

endmodule

`default_nettype wire

// ===== rtl/tdm_switch.sv
// Time-division switch: eight serial inputs into a data memory, eight
// serial outputs from it or from the connection memory, a control stream,
// and the asynchronous processor port.
// Assumes the bit clock and frame pulse pins are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "tdm_switch_defines.svh"

module tdm_switch #(
    parameter int FRAME_TICKS = `FRAME_TICKS
) (
    input wire logic clk,
    input wire logic rst,
    cpu_port_if.device bus,
    input wire logic bit_clock_x2_n,
    input wire logic frame_pulse_n,
    input wire logic [7:0] serial_in,
    input wire logic output_drive_enable,
    output logic [7:0] serial_out,
    output logic [7:0] serial_out_oe,
    output logic control_stream_out
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] data_mem [0:255];
    logic [7:0] conn_lo [0:255];
    logic [7:0] conn_hi [0:255];
    logic [7:0] ctrl_ff;
    tdm_switch_pkg::dev_state_t state_ff;
    logic [5:0] addr_ff;
    logic read_ff;
    logic [7:0] wdata_ff;
    logic [7:0] rdata_ff;
    logic ack_oe_ff;
    logic data_oe_ff;
    logic bit_clk_prev_ff;
    logic [8:0] tick_ff;
    logic [8:0] nxt_tick;
    logic fall;
    logic [7:0] in_sh_ff [0:7];
    logic [7:0] out_sh_ff [0:7];
    logic [7:0] chan_en_ff;
    logic [7:0] serial_out_ff;
    logic [7:0] serial_out_oe_ff;
    logic cst_ff;
    logic [7:0] load_byte [0:7];
    logic [7:0] load_en;
    logic [4:0] chan;
    logic [4:0] next_chan;
    logic [2:0] bit_pos;
    logic [7:0] mem_idx;
    tdm_switch_pkg::mem_sel_t sel;

    // ------------------------------------------------------------------
    // Frame timing
    // ------------------------------------------------------------------
    // Falling edge of the sampled double-rate bit clock.
    assign fall = bit_clk_prev_ff & ~bit_clock_x2_n;
    // Count advances per bit clock period and wraps once per frame.
    assign nxt_tick = (~frame_pulse_n) ? 9'h000 :
                      ((32'(tick_ff) == FRAME_TICKS - 1) ? 9'h000 :
                       tick_ff + 9'h001);
    // Two periods per bit, eight bits per channel, 32 channels.
    assign bit_pos = nxt_tick[3:1];
    assign chan = nxt_tick[8:4];
    assign next_chan = chan + 5'h01;

    // Previous bit clock level for edge detection.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_clk_prev_ff <= 1'b1;
        end else begin
            bit_clk_prev_ff <= bit_clock_x2_n;
        end
    end

    // Frame position counter, realigned by the frame pulse.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_ff <= 9'h000;
        end else if (fall) begin
            tick_ff <= nxt_tick;
        end
    end

    // ------------------------------------------------------------------
    // Serial receive
    // ------------------------------------------------------------------
    // Inputs are sampled mid-cell; a full byte goes to the data memory.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < `STREAMS; s++) begin
                in_sh_ff[s] <= 8'h00;
            end
        end else if (fall && nxt_tick[0]) begin
            for (int s = 0; s < `STREAMS; s++) begin
                in_sh_ff[s] <= {in_sh_ff[s][6:0], serial_in[s]};
            end
        end
    end

    // Data memory write at the last bit of each channel.
    always_ff @(posedge clk) begin
        if (fall && nxt_tick[0] && bit_pos == 3'h7) begin
            for (int s = 0; s < `STREAMS; s++) begin
                data_mem[{3'(s), chan}] <= {in_sh_ff[s][6:0], serial_in[s]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial transmit
    // ------------------------------------------------------------------
    // Per stream: pick message byte or switched byte and driver enable.
    for (genvar s = 0; s < `STREAMS; s++) begin : g_out
        logic [7:0] idx;
        logic msg;
        assign idx = {3'(s), chan};
        assign msg = ctrl_ff[`CTRL_MSG_BIT] | conn_hi[idx][`CMH_MSG_BIT];
        assign load_byte[s] = msg ? conn_lo[idx] : data_mem[conn_lo[idx]];
        assign load_en[s] = ctrl_ff[`CTRL_MSG_BIT] |
                            conn_hi[idx][`CMH_OE_BIT];
    end

    // Bits change on cell boundaries, most significant bit first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_out_ff <= 8'h00;
            chan_en_ff <= 8'h00;
            for (int s = 0; s < `STREAMS; s++) begin
                out_sh_ff[s] <= 8'h00;
            end
        end else if (fall && !nxt_tick[0]) begin
            for (int s = 0; s < `STREAMS; s++) begin
                if (bit_pos == 3'h0) begin
                    serial_out_ff[s] <= load_byte[s][7];
                    out_sh_ff[s] <= {load_byte[s][6:0], 1'b0};
                    chan_en_ff[s] <= load_en[s];
                end else begin
                    serial_out_ff[s] <= out_sh_ff[s][7];
                    out_sh_ff[s] <= {out_sh_ff[s][6:0], 1'b0};
                end
            end
        end
    end

    // Drive enable pin overrides every channel enable at once.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_out_oe_ff <= 8'h00;
        end else begin
            serial_out_oe_ff <= output_drive_enable ?
                                chan_en_ff : 8'h00;
        end
    end

    // Control stream: stream 0 first, one channel ahead.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cst_ff <= 1'b0;
        end else if (fall && !nxt_tick[0]) begin
            cst_ff <= conn_hi[{bit_pos, next_chan}][`CMH_CST_BIT];
        end
    end

    assign serial_out = serial_out_ff;
    assign serial_out_oe = serial_out_oe_ff;
    assign control_stream_out = cst_ff;

    // ------------------------------------------------------------------
    // Processor port
    // ------------------------------------------------------------------
    assign sel = tdm_switch_pkg::mem_sel_t'(
                 ctrl_ff[`CTRL_SEL_HI:`CTRL_SEL_LO]);
    assign mem_idx = {ctrl_ff[`CTRL_STREAM_HI:0], addr_ff[4:0]};

    // Access sequencer: take, process, acknowledge until strobe drops.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= tdm_switch_pkg::DEV_IDLE;
            addr_ff <= 6'h00;
            read_ff <= 1'b0;
            wdata_ff <= 8'h00;
        end else begin
            unique case (state_ff)
                tdm_switch_pkg::DEV_IDLE: begin
                    // Selected by low chip select and high strobe.
                    if (!bus.chip_select_n && bus.data_strobe) begin
                        state_ff <= tdm_switch_pkg::DEV_BUSY;
                        addr_ff <= bus.port_addr;
                        read_ff <= bus.read_write;
                        wdata_ff <= bus.port_data;
                    end
                end
                tdm_switch_pkg::DEV_BUSY: begin
                    state_ff <= tdm_switch_pkg::DEV_ACK;
                end
                tdm_switch_pkg::DEV_ACK: begin
                    if (bus.chip_select_n || !bus.data_strobe) begin
                        state_ff <= tdm_switch_pkg::DEV_IDLE;
                    end
                end
                default: begin
                    state_ff <= tdm_switch_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // Writes to the control byte or the connection memories.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `CTRL_RESET;
        end else if (state_ff == tdm_switch_pkg::DEV_BUSY && !read_ff &&
                     !addr_ff[`ADDR_MEM_BIT]) begin
            ctrl_ff <= wdata_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (state_ff == tdm_switch_pkg::DEV_BUSY && !read_ff &&
            addr_ff[`ADDR_MEM_BIT]) begin
            // Split mode sends every write to the lower memory.
            if (ctrl_ff[`CTRL_SPLIT_BIT] ||
                sel == tdm_switch_pkg::SEL_CONN_LO) begin
                conn_lo[mem_idx] <= wdata_ff;
            end else if (sel == tdm_switch_pkg::SEL_CONN_HI) begin
                conn_hi[mem_idx] <= wdata_ff;
            end
        end
    end

    // Read data captured while processing; split mode reads data memory.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (state_ff == tdm_switch_pkg::DEV_BUSY) begin
            if (!addr_ff[`ADDR_MEM_BIT]) begin
                rdata_ff <= ctrl_ff;
            end else if (ctrl_ff[`CTRL_SPLIT_BIT] ||
                         sel == tdm_switch_pkg::SEL_DATA ||
                         sel == tdm_switch_pkg::SEL_DATA_ALT) begin
                rdata_ff <= data_mem[mem_idx];
            end else if (sel == tdm_switch_pkg::SEL_CONN_LO) begin
                rdata_ff <= conn_lo[mem_idx];
            end else begin
                rdata_ff <= conn_hi[mem_idx];
            end
        end
    end

    // Acknowledge and data drive follow the sequencer.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_oe_ff <= 1'b0;
            data_oe_ff <= 1'b0;
        end else begin
            ack_oe_ff <= (state_ff == tdm_switch_pkg::DEV_BUSY) ||
                         (state_ff == tdm_switch_pkg::DEV_ACK &&
                          !bus.chip_select_n && bus.data_strobe);
            data_oe_ff <= read_ff &&
                          ((state_ff == tdm_switch_pkg::DEV_BUSY) ||
                           (state_ff == tdm_switch_pkg::DEV_ACK &&
                            !bus.chip_select_n &&
                            bus.data_strobe));
        end
    end

    assign bus.xfer_ack_n_out = 1'b0;
    assign bus.xfer_ack_oe = ack_oe_ff;
    assign bus.dev_data_out = rdata_ff;
    assign bus.dev_data_oe = data_oe_ff;

endmodule

`default_nettype wire

// ===== sim/tdm_switch_chk.sv
// Checker for the processor port joining the two ends of the switch.
// Assumes it stands beside the interface and sees its plain signals.
`timescale 1ns/100ps
`default_nettype none

module tdm_switch_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic data_strobe,
    input wire logic read_write,
    input wire logic [5:0] port_addr,
    input wire logic host_data_oe,
    input wire logic dev_data_oe,
    input wire logic xfer_ack_oe,
    input wire logic [7:0] port_data
);
    // ------------------------------------------------------------------
    // Handshake and bus direction
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ack_when_selected: assert property (
        $rose(xfer_ack_oe) |-> !chip_select_n && data_strobe)
        else $error("ack raised without a selected strobe");
    a_ack_answer_time: assert property (
        $rose(data_strobe) |-> ##[1:3] xfer_ack_oe)
        else $error("ack late after strobe");
    a_ack_release: assert property (
        (chip_select_n || !data_strobe) |-> ##[0:4] !xfer_ack_oe)
        else $error("ack not released after strobe end");
    a_no_bus_fight: assert property (
        !(dev_data_oe && host_data_oe))
        else $error("both ends drive the data bus");
    a_dev_drives_reads: assert property (
        $rose(dev_data_oe) |-> read_write && !chip_select_n)
        else $error("switch drives data outside a read");
    a_host_drives_writes: assert property (
        $rose(host_data_oe) |-> !read_write)
        else $error("host drives data outside a write");
    a_strobe_held: assert property (
        data_strobe && xfer_ack_oe == 1'b0 |=> data_strobe)
        else $error("strobe dropped before ack");
    a_addr_held: assert property (
        data_strobe && $past(data_strobe) |-> $stable(port_addr)
        && $stable(read_write))
        else $error("address or direction moved in an access");
    a_select_with_strobe: assert property (
        data_strobe |-> !chip_select_n)
        else $error("strobe without chip select");
    a_read_data_held: assert property (
        dev_data_oe && $past(dev_data_oe) |-> $stable(port_data))
        else $error("read data moved while driven");

    c_write: cover property ($rose(host_data_oe) ##[1:9] xfer_ack_oe);
    c_read: cover property ($rose(dev_data_oe));
    c_release: cover property ($fell(xfer_ack_oe));
endmodule

`default_nettype wire

// ===== sim/tdm_switch_pin_interface_bench.sv
// Bench for the switch and its processor end, joined by the port.
// Assumes the bit clock and frame pulse are made here in step with clk.
`timescale 1ns/100ps
`default_nettype none
`include "tdm_switch_defines.svh"

module tdm_switch_pin_interface_bench;
    // ------------------------------------------------------------------
    // Stimulus, models of the streams and checks
    // ------------------------------------------------------------------
    logic clk = 0, rst = 1, req = 0, req_write = 0, done, busy;
    logic [5:0] req_addr = 0;
    logic [7:0] req_wdata = 0, rdata, serial_out, serial_out_oe, ctrl = 0;
    logic bit_clock_x2_n = 1, frame_pulse_n = 1, output_drive_enable = 0;
    logic [7:0] serial_in = 0, v, lv;
    logic control_stream_out, watch = 0, fp_on = 1, oe;
    logic [8:0] e;
    logic [2:0] h;
    int fail_count = 0, checks_done = 0, tick = 300, div = 0;

    cpu_port_if cpu_port_if_i ();
    tdm_switch #(.FRAME_TICKS(512)) tdm_switch_i (.clk(clk), .rst(rst),
        .bus(cpu_port_if_i), .bit_clock_x2_n(bit_clock_x2_n),
        .frame_pulse_n(frame_pulse_n), .serial_in(serial_in),
        .output_drive_enable(output_drive_enable),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .control_stream_out(control_stream_out));
    cpu_port_master cpu_port_master_i (.clk(clk), .rst(rst),
        .bus(cpu_port_if_i), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done),
        .rdata(rdata));
    tdm_switch_chk tdm_switch_chk_i (.clk(clk), .rst(rst),
        .chip_select_n(cpu_port_if_i.chip_select_n),
        .data_strobe(cpu_port_if_i.data_strobe),
        .read_write(cpu_port_if_i.read_write),
        .port_addr(cpu_port_if_i.port_addr),
        .host_data_oe(cpu_port_if_i.host_data_oe),
        .dev_data_oe(cpu_port_if_i.dev_data_oe),
        .xfer_ack_oe(cpu_port_if_i.xfer_ack_oe),
        .port_data(cpu_port_if_i.port_data));

    function automatic logic [7:0] pat(logic [2:0] s, logic [4:0] c);
        return {s, c} ^ 8'hA5;
    endfunction
    function automatic logic [7:0] lo(logic [2:0] s, logic [4:0] c);
        return {s, c} ^ 8'h3C;
    endfunction
    // Upper memory contents: message, control stream bit, driver enable.
    function automatic logic [2:0] hi(logic [2:0] s, logic [4:0] c);
        return {c[0], s[0] ^ c[1], c != 5'h07};
    endfunction
    function automatic logic pick(logic [7:0] x, logic [2:0] b);
        return x[3'h7 - b];
    endfunction

    task automatic check(logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One access through the processor end, waiting on its done pulse.
    task automatic access(logic wr, logic [5:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #2;
        req = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        #2;
        req = 1'b0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk);
            #2;
            n++;
        end
        if (done !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: access not done", $time);
        end
        check(8'(busy), 8'h00);
    endtask

    task automatic setc(logic [7:0] x);
        access(1'b1, 6'h00, x);
        ctrl = x;
    endtask

    // Lets the outputs settle, then checks one whole frame.
    task automatic frame();
        @(posedge clk iff (tick == 256));
        @(posedge clk iff (tick == 1 && div == 1));
        watch = 1;
        @(posedge clk iff (tick == 1 && div == 1));
        watch = 0;
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always #12.5 clk = ~clk;

    // Bit clock of ten clk periods; drives inputs, samples mid-cell.
    always @(posedge clk) begin
        #2;
        div = (div + 1) % 10;
        bit_clock_x2_n = (div >= 5);
        if (div == 0) begin
            tick = (tick + 1) % 512;
            e = 9'(tick);
            for (int s = 0; s < 8 && !e[0]; s++)
                serial_in[s] = pick(pat(3'(s), e[8:4]), e[3:1]);
            e = 9'(tick - 1);
            for (int s = 0; s < 8 && e[0] == 0 && tick[0] && watch; s++) begin
                h = hi(3'(s), e[8:4]);
                oe = output_drive_enable & (ctrl[6] | h[0]);
                check(8'(serial_out_oe[s]), 8'(oe));
                lv = lo(3'(s), e[8:4]);
                v = (ctrl[6] | h[2]) ? lv : pat(lv[7:5], lv[4:0]);
                if (oe)
                    check(8'(serial_out[s]), 8'(pick(v, e[3:1])));
            end
            if (tick[0] && watch) begin
                h = hi(e[3:1], e[8:4] + 5'h01);
                check(8'(control_stream_out), 8'(h[1]));
            end
        end
        frame_pulse_n = !(fp_on && ((tick == 511 && div >= 5)
            || (tick == 0 && div < 5)));
    end

    initial begin
        #1500000;
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        results();
    end

    // Main sequence of tests.
    initial begin
        repeat (5) @(posedge clk);
        #2;
        rst = 0;
        access(1'b0, 6'h1F, 8'h00);
        check(rdata, `CTRL_RESET);
        access(1'b1, 6'h0A, 8'h1B);
        access(1'b0, 6'h15, 8'h00);
        check(rdata, 8'h1B);
        $display("Test control byte done");
        for (int s = 0; s < 8; s++) begin
            setc(8'h18 | 8'(s));
            for (int c = 0; c < 32; c++)
                access(1'b1, 6'h20 | 6'(c), {5'h00, hi(3'(s), 5'(c))});
            setc(8'h10 | 8'(s));
            for (int c = 0; c < 32; c++)
                access(1'b1, 6'h20 | 6'(c), lo(3'(s), 5'(c)));
        end
        access(1'b0, 6'h25, 8'h00);
        check(rdata, lo(3'h7, 5'h05));
        $display("Test memory load done");
        setc(8'h00);
        output_drive_enable = 1;
        frame();
        $display("Test switched frame done");
        for (int s = 0; s < 8; s++) begin
            // Odd streams use the second data memory select code.
            setc((s[0] ? 8'h00 : 8'h08) | 8'(s));
            access(1'b0, 6'h20 | 6'(3 * s + 1), 8'h00);
            check(rdata, pat(3'(s), 5'(3 * s + 1)));
        end
        // Split mode reads the data memory and writes the lower memory.
        setc(8'h82);
        access(1'b0, 6'h25, 8'h00);
        check(rdata, pat(3'h2, 5'h05));
        access(1'b1, 6'h25, 8'h5A);
        setc(8'h12);
        access(1'b0, 6'h25, 8'h00);
        check(rdata, 8'h5A);
        access(1'b1, 6'h25, lo(3'h2, 5'h05));
        $display("Test input capture done");
        setc(8'h00);
        output_drive_enable = 0;
        frame();
        $display("Test drive off done");
        setc(8'h40);
        output_drive_enable = 1;
        fp_on = 0;
        frame();
        $display("Test message frame done");
        results();
    end
endmodule

`default_nettype wire
